// >>> pkg/fsmsl_pkg.sv
// constants, types and the list of functions of the fan speed mode logic
// Function
// - control pulses of 30 ms or less are ignored; sources hold longer
// - start sequence once after power-up, or every switch-on with cutoff
// - timer mode takes its pulse from the remote switch input
// - logic mode takes its pulse from the analog control input
// - bus mode takes ceiling, floor, start, cutoff settings from bus
// - standalone mode takes those settings from board switches and trimmers
// - green lamp steady while running in normal operation
// - green lamp blinks in remote standby or past cutoff threshold (below ascending, above descending)
// - full-scale input gives maximum ascending, minimum descending
// - cutoff enabled and descending: full-scale input stops the motor unless the threshold is 100
// - cutoff enabled and ascending: zero input stops the motor unless the threshold is 0
// - input equal to threshold runs minimum ascending, maximum descending
// - both lamps blink after an active bus network is detected
// - input level register reports 0 to 100 of full scale
// - input kind register reads 0 for current, 1 for voltage
// - direction register reads 0 descending, 1 ascending
// - threshold held 0 to 40 ascending, 60 to 100 descending
// - start style register reads 0 soft, 1 kick
// - operating mode 0 standalone, 1 bus control disabling board settings but the remote mode
package fsmsl_pkg;

  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int TICK_PERIOD_NS = 1000000;   // one millisecond
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PULSE_MIN_MS   = 30;        // accepted only when longer
  localparam int BLINK_HALF_MS  = 500;
  localparam int KICK_MS        = 1000;
  localparam int SOFT_STEP_MS   = 20;
  localparam int NET_TOGGLES    = 10;        // lamp toggles of the net show
  localparam int MS_W           = 11;

  // ---------------------------------------------------------------------
  // percent limits
  // ---------------------------------------------------------------------
  localparam logic [6:0] PCT_ZERO     = 7'h00;
  localparam logic [6:0] PCT_FULL     = 7'h64;  // 100
  localparam logic [6:0] FLOOR_LO     = 7'h1E;  // 30
  localparam logic [6:0] FLOOR_HI     = 7'h46;  // 70
  localparam logic [6:0] CEIL_LO      = 7'h4B;  // 75
  localparam logic [6:0] CUT_ASC_HI   = 7'h28;  // 40
  localparam logic [6:0] CUT_DESC_LO  = 7'h3C;  // 60
  localparam logic [5:0] DIV100_MUL   = 6'h29;  // 41/4096 ~ 1/100
  localparam int         DIV100_SHIFT = 12;

  // ---------------------------------------------------------------------
  // input register map
  // ---------------------------------------------------------------------
  localparam logic [4:0] IR_INPUT_LEVEL = 5'h01;
  localparam logic [4:0] IR_OUTPUT_PCT  = 5'h02;
  localparam logic [4:0] IR_INPUT_KIND  = 5'h03;
  localparam logic [4:0] IR_DIRECTION   = 5'h04;
  localparam logic [4:0] IR_CEILING     = 5'h05;
  localparam logic [4:0] IR_FLOOR       = 5'h06;
  localparam logic [4:0] IR_CUT_ENABLE  = 5'h07;
  localparam logic [4:0] IR_CUT_VALUE   = 5'h08;
  localparam logic [4:0] IR_START_STYLE = 5'h09;
  localparam logic [4:0] IR_REMOTE_IN   = 5'h0A;
  localparam logic [4:0] IR_BYPASS      = 5'h0C;
  localparam logic [4:0] IR_FAULT_LAMP  = 5'h0D;
  localparam logic [4:0] IR_POWER_LAMP  = 5'h0E;
  localparam logic [15:0] RD_ZERO       = 16'h0000;

  // power lamp report codes
  localparam logic [1:0] LAMP_OFF     = 2'h0;
  localparam logic [1:0] LAMP_ON      = 2'h1;
  localparam logic [1:0] LAMP_STANDBY = 2'h2;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSMSL_REM_NORMAL,
    FSMSL_REM_TIMER,
    FSMSL_REM_LOGIC
  } fsmsl_rem_mode_t;

  typedef enum logic [1:0] {
    FSMSL_ST_IDLE,
    FSMSL_ST_KICK,
    FSMSL_ST_SOFT,
    FSMSL_ST_RUN
  } fsmsl_start_t;

endpackage : fsmsl_pkg

// >>> logic/fsmsl_pulse_filter.sv
// pulse width filter: output follows input only after a long enough hold
`timescale 1ns/10ps
module fsmsl_pulse_filter #(
  parameter int MIN_TICKS = 30
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // timing
  input  wire logic tick,
  // level in and out
  input  wire logic din,
  output logic      dout_q
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       differ;
  logic       accept;

  // a level must survive more than MIN_TICKS ticks, so the count
  // needs MIN_TICKS+1 ticks; the first partial tick always counts
  assign differ = din != dout_q;
  assign accept = differ && tick && (cnt_q == 8'(MIN_TICKS));
  assign cnt_d  = !differ ? 8'h00 :
                  (tick ? cnt_q + 8'h01 : cnt_q);

  // count and accept
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q  <= 8'h00;
      dout_q <= 1'b0;
    end else begin
      cnt_q <= accept ? 8'h00 : cnt_d;
      if (accept) begin
        dout_q <= din;
      end
    end
  end

endmodule : fsmsl_pulse_filter

// >>> logic/fsmsl_top.sv
// fan speed mode, start, cutoff, lamp and input register logic
`timescale 1ns/10ps
module fsmsl_top #(
  parameter int TICK_CYCLES = fsmsl_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // analog input, already converted to percent of full scale
  input  wire logic [6:0]  analog_level,
  input  wire logic        analog_logic_high,
  // board switches and trimmers
  input  wire logic        board_current_sel,
  input  wire logic        board_ascending,
  input  wire logic [6:0]  board_ceiling,
  input  wire logic [6:0]  board_floor,
  input  wire logic        board_kick,
  input  wire logic        board_cut_en,
  input  wire logic [6:0]  board_cut_value,
  input  wire logic [1:0]  board_rem_mode,
  // holding register values from the bus side
  input  wire logic        bus_mode,
  input  wire logic        bus_current_sel,
  input  wire logic        bus_ascending,
  input  wire logic [6:0]  bus_ceiling,
  input  wire logic [6:0]  bus_floor,
  input  wire logic        bus_kick,
  input  wire logic        bus_cut_en,
  input  wire logic [6:0]  bus_cut_value,
  input  wire logic        bus_net_seen,
  // pins
  input  wire logic        remote_switch_input,
  input  wire logic        motor_fault,
  // input register read port
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  output logic [15:0]      reg_rdata_q,
  output logic             reg_rvalid_q,
  // outputs to power stage and lamps
  output logic [6:0]       out_percent_q,
  output logic             motor_run_q,
  output logic             bypass_output_q,
  output logic             green_lamp_q,
  output logic             fault_lamp_q
);

  // -----------------------------------------------------------------------
  // millisecond tick divider
  // -----------------------------------------------------------------------
  logic [17:0] div_q;
  logic        tick;

  assign tick = div_q == 18'(TICK_CYCLES - 1);

  // free-running divider, one-cycle enable each millisecond
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      div_q <= 18'h00000;
    end else begin
      div_q <= tick ? 18'h00000 : div_q + 18'h00001;
    end
  end

  // -----------------------------------------------------------------------
  // setting source selection
  // -----------------------------------------------------------------------
  logic       cur_sel;
  logic       ascending;
  logic [6:0] ceil_raw;
  logic [6:0] floor_raw;
  logic       kick;
  logic       cut_en;
  logic [6:0] cut_raw;

  // bus control shuts out every board setting except the remote mode
  assign cur_sel   = bus_mode ? bus_current_sel : board_current_sel;
  assign ascending = bus_mode ? bus_ascending   : board_ascending;
  assign ceil_raw  = bus_mode ? bus_ceiling     : board_ceiling;
  assign floor_raw = bus_mode ? bus_floor       : board_floor;
  assign kick      = bus_mode ? bus_kick        : board_kick;
  assign cut_en    = bus_mode ? bus_cut_en      : board_cut_en;
  assign cut_raw   = bus_mode ? bus_cut_value   : board_cut_value;

  // -----------------------------------------------------------------------
  // range clamps: bus values are not trusted to be in range
  // -----------------------------------------------------------------------
  logic [6:0] level;
  logic [6:0] ceil_v;
  logic [6:0] floor_v;
  logic [6:0] cut_v;

  // clamp each setting into its documented window
  assign level   = (analog_level > fsmsl_pkg::PCT_FULL) ?
                   fsmsl_pkg::PCT_FULL : analog_level;
  assign ceil_v  = (ceil_raw < fsmsl_pkg::CEIL_LO) ? fsmsl_pkg::CEIL_LO :
                   (ceil_raw > fsmsl_pkg::PCT_FULL) ?
                   fsmsl_pkg::PCT_FULL : ceil_raw;
  assign floor_v = (floor_raw < fsmsl_pkg::FLOOR_LO) ? fsmsl_pkg::FLOOR_LO :
                   (floor_raw > fsmsl_pkg::FLOOR_HI) ?
                   fsmsl_pkg::FLOOR_HI : floor_raw;
  assign cut_v   = ascending ?
                   ((cut_raw > fsmsl_pkg::CUT_ASC_HI) ?
                    fsmsl_pkg::CUT_ASC_HI : cut_raw) :
                   ((cut_raw < fsmsl_pkg::CUT_DESC_LO) ?
                    fsmsl_pkg::CUT_DESC_LO :
                    (cut_raw > fsmsl_pkg::PCT_FULL) ?
                    fsmsl_pkg::PCT_FULL : cut_raw);

  // -----------------------------------------------------------------------
  // speed law: linear between floor and ceiling
  // -----------------------------------------------------------------------
  logic [6:0]  eff;
  logic [6:0]  span;
  logic [13:0] prod;
  logic [19:0] scaled;
  logic [6:0]  lin;
  logic        at_cut;
  logic        cut_stop;
  logic [6:0]  target;

  // descending mode runs the law backwards; a divide by 100 is replaced
  // by a multiply and shift that is exact at both ends of the span
  assign eff    = ascending ? level : fsmsl_pkg::PCT_FULL - level;
  assign span   = ceil_v - floor_v;
  assign prod   = span * eff;
  assign scaled = prod * fsmsl_pkg::DIV100_MUL;
  assign lin    = floor_v + scaled[fsmsl_pkg::DIV100_SHIFT +: 7];

  // cutoff: below threshold ascending or above it descending stops, end of scale stops unless it equals the threshold
  assign at_cut   = cut_en && (level == cut_v);
  assign cut_stop = cut_en && !at_cut &&
                    (ascending ?
                     ((level < cut_v) || (level == fsmsl_pkg::PCT_ZERO)) :
                     ((level > cut_v) ||
                      (level == fsmsl_pkg::PCT_FULL)));

  // exactly on the threshold holds the floor ascending, the ceiling descending
  assign target = !at_cut ? lin :
                  (ascending ? floor_v : ceil_v);

  // -----------------------------------------------------------------------
  // remote control pulse path
  // -----------------------------------------------------------------------
  logic pulse_src;
  logic pulse_lvl;
  logic pulse_lvl_q;
  logic pulse_rise;
  logic pulse_mode;
  logic pulse_run_q;

  // normal and timer modes listen to the switch, logic mode to the
  // analog pin's comparator; one filter serves all three
  assign pulse_src  = (board_rem_mode == fsmsl_pkg::FSMSL_REM_LOGIC) ?
                      analog_logic_high :
                      remote_switch_input;
  assign pulse_mode = (board_rem_mode == fsmsl_pkg::FSMSL_REM_TIMER) ||
                      (board_rem_mode == fsmsl_pkg::FSMSL_REM_LOGIC);
  assign pulse_rise = pulse_lvl && !pulse_lvl_q;

  fsmsl_pulse_filter #(
    .MIN_TICKS (fsmsl_pkg::PULSE_MIN_MS)
  ) u_filter (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .tick   (tick),
    .din    (pulse_src),
    .dout_q (pulse_lvl)
  );

  // each accepted pulse toggles run and standby in the pulse modes
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pulse_lvl_q <= 1'b0;
      pulse_run_q <= 1'b0;
    end else begin
      pulse_lvl_q <= pulse_lvl;
      if (!pulse_mode) begin
        pulse_run_q <= 1'b0;
      end else if (pulse_rise) begin
        pulse_run_q <= !pulse_run_q;
      end
    end
  end

  logic remote_on;
  logic standby;
  logic run_req;

  assign remote_on = pulse_mode ? pulse_run_q : pulse_lvl;
  assign standby   = !remote_on;
  assign run_req   = remote_on && !cut_stop && !motor_fault;

  // -----------------------------------------------------------------------
  // start sequence
  // -----------------------------------------------------------------------
  fsmsl_pkg::fsmsl_start_t st_q;
  fsmsl_pkg::fsmsl_start_t st_d;
  logic [fsmsl_pkg::MS_W-1:0] st_ms_q;
  logic [6:0]  ramp_q;
  logic        started_q;
  logic        need_start;
  logic        kick_done;
  logic        step_due;
  logic        ramp_top;

  // without cutoff the start runs once per power-up; with cutoff it runs
  // on every switch-on, since cutoff stops are part of normal operation
  assign need_start = cut_en || !started_q;
  assign kick_done  = tick &&
                      (st_ms_q == fsmsl_pkg::MS_W'(fsmsl_pkg::KICK_MS - 1));
  // steps only while ramping, or the shared count never reaches kick end
  assign step_due   = tick && (st_q == fsmsl_pkg::FSMSL_ST_SOFT) &&
                      (st_ms_q ==
                       fsmsl_pkg::MS_W'(fsmsl_pkg::SOFT_STEP_MS - 1));
  assign ramp_top   = ramp_q >= target;

  // next state of the start sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      fsmsl_pkg::FSMSL_ST_IDLE: begin
        if (run_req) begin
          if (!need_start) begin
            st_d = fsmsl_pkg::FSMSL_ST_RUN;
          end else if (kick) begin
            st_d = fsmsl_pkg::FSMSL_ST_KICK;
          end else begin
            st_d = fsmsl_pkg::FSMSL_ST_SOFT;
          end
        end
      end
      fsmsl_pkg::FSMSL_ST_KICK: begin
        if (!run_req) begin
          st_d = fsmsl_pkg::FSMSL_ST_IDLE;
        end else if (kick_done) begin
          st_d = fsmsl_pkg::FSMSL_ST_RUN;
        end
      end
      fsmsl_pkg::FSMSL_ST_SOFT: begin
        if (!run_req) begin
          st_d = fsmsl_pkg::FSMSL_ST_IDLE;
        end else if (ramp_top) begin
          st_d = fsmsl_pkg::FSMSL_ST_RUN;
        end
      end
      fsmsl_pkg::FSMSL_ST_RUN: begin
        if (!run_req) begin
          st_d = fsmsl_pkg::FSMSL_ST_IDLE;
        end
      end
      default: begin
        st_d = fsmsl_pkg::FSMSL_ST_IDLE;
      end
    endcase
  end

  // sequencer state, millisecond timer and soft ramp
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q      <= fsmsl_pkg::FSMSL_ST_IDLE;
      st_ms_q   <= '0;
      ramp_q    <= fsmsl_pkg::FLOOR_LO;
      started_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (st_d != st_q || kick_done || step_due) begin
        st_ms_q <= '0;
      end else if (tick) begin
        st_ms_q <= st_ms_q + 1'b1;
      end
      if (st_q == fsmsl_pkg::FSMSL_ST_IDLE) begin
        ramp_q <= fsmsl_pkg::FLOOR_LO;
      end else if (st_q == fsmsl_pkg::FSMSL_ST_SOFT && step_due) begin
        ramp_q <= ramp_q + 7'h01;
      end
      if (st_q == fsmsl_pkg::FSMSL_ST_RUN) begin
        started_q <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // output level
  // -----------------------------------------------------------------------
  logic [6:0] out_d;

  // off reads zero; every running value stays inside 30..100
  assign out_d = (st_q == fsmsl_pkg::FSMSL_ST_KICK) ? fsmsl_pkg::PCT_FULL :
                 (st_q == fsmsl_pkg::FSMSL_ST_SOFT) ? ramp_q :
                 (st_q == fsmsl_pkg::FSMSL_ST_RUN)  ? target :
                 fsmsl_pkg::PCT_ZERO;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out_percent_q   <= fsmsl_pkg::PCT_ZERO;
      motor_run_q     <= 1'b0;
      bypass_output_q <= 1'b0;
    end else begin
      out_percent_q   <= out_d;
      motor_run_q     <= st_q != fsmsl_pkg::FSMSL_ST_IDLE;
      bypass_output_q <= remote_on && !motor_fault;
    end
  end

  // -----------------------------------------------------------------------
  // lamp blink timebase and network show
  // -----------------------------------------------------------------------
  logic [fsmsl_pkg::MS_W-1:0] blink_ms_q;
  logic       blink_q;
  logic       blink_flip;
  logic [3:0] net_cnt_q;
  logic       net_show_q;
  logic       net_done_q;

  assign blink_flip = tick &&
                      (blink_ms_q ==
                       fsmsl_pkg::MS_W'(fsmsl_pkg::BLINK_HALF_MS - 1));

  // half-period counter shared by every blinking lamp
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      blink_ms_q <= '0;
      blink_q    <= 1'b0;
    end else if (blink_flip) begin
      blink_ms_q <= '0;
      blink_q    <= !blink_q;
    end else if (tick) begin
      blink_ms_q <= blink_ms_q + 1'b1;
    end
  end

  // the network show plays once per power-up, then lamps return
  // to their normal meaning
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      net_show_q <= 1'b0;
      net_done_q <= 1'b0;
      net_cnt_q  <= 4'h0;
    end else if (!net_show_q && !net_done_q && bus_net_seen) begin
      net_show_q <= 1'b1;
    end else if (net_show_q && blink_flip) begin
      if (net_cnt_q == 4'(fsmsl_pkg::NET_TOGGLES - 1)) begin
        net_show_q <= 1'b0;
        net_done_q <= 1'b1;
      end else begin
        net_cnt_q <= net_cnt_q + 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // lamps
  // -----------------------------------------------------------------------
  logic       lamp_blinking;
  logic [1:0] power_code;

  assign lamp_blinking = standby || cut_stop;
  assign power_code    = motor_fault   ? fsmsl_pkg::LAMP_OFF :
                         lamp_blinking ? fsmsl_pkg::LAMP_STANDBY :
                         fsmsl_pkg::LAMP_ON;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      green_lamp_q <= 1'b0;
      fault_lamp_q <= 1'b0;
    end else if (net_show_q) begin
      green_lamp_q <= blink_q;
      fault_lamp_q <= blink_q;
    end else begin
      green_lamp_q <= lamp_blinking ? blink_q : !motor_fault;
      fault_lamp_q <= motor_fault;
    end
  end

  // -----------------------------------------------------------------------
  // input register read port
  // -----------------------------------------------------------------------
  logic [15:0] rd_word;

  // unmapped and reserved words read zero; nothing here is writable
  assign rd_word =
    (reg_addr == fsmsl_pkg::IR_INPUT_LEVEL) ? {9'h000, level} :
    (reg_addr == fsmsl_pkg::IR_OUTPUT_PCT)  ? {9'h000, out_percent_q} :
    (reg_addr == fsmsl_pkg::IR_INPUT_KIND)  ? {15'h0000, !cur_sel} :
    (reg_addr == fsmsl_pkg::IR_DIRECTION)   ? {15'h0000, ascending} :
    (reg_addr == fsmsl_pkg::IR_CEILING)     ? {9'h000, ceil_v} :
    (reg_addr == fsmsl_pkg::IR_FLOOR)       ? {9'h000, floor_v} :
    (reg_addr == fsmsl_pkg::IR_CUT_ENABLE)  ? {15'h0000, cut_en} :
    (reg_addr == fsmsl_pkg::IR_CUT_VALUE)   ? {9'h000, cut_v} :
    (reg_addr == fsmsl_pkg::IR_START_STYLE) ? {15'h0000, kick} :
    (reg_addr == fsmsl_pkg::IR_REMOTE_IN)   ? {15'h0000, remote_on} :
    (reg_addr == fsmsl_pkg::IR_BYPASS)   ? {15'h0000, bypass_output_q} :
    (reg_addr == fsmsl_pkg::IR_FAULT_LAMP)  ? {15'h0000, fault_lamp_q} :
    (reg_addr == fsmsl_pkg::IR_POWER_LAMP)  ? {14'h0000, power_code} :
    fsmsl_pkg::RD_ZERO;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata_q  <= fsmsl_pkg::RD_ZERO;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        reg_rdata_q <= rd_word;
      end
    end
  end

endmodule : fsmsl_top

// >>> verif/fsmsl_checker.sv
// concurrent checks on the ports of the fan speed mode logic
`timescale 1ns/10ps
module fsmsl_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // settings watched
  input wire logic        bus_mode,
  input wire logic        board_current_sel,
  input wire logic        bus_ascending,
  // read port
  input wire logic        reg_rd,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] reg_rdata_q,
  input wire logic        reg_rvalid_q,
  // outputs
  input wire logic [6:0]  out_percent_q,
  input wire logic        bypass_output_q
);
  // ---------------------------------------------------------------
  // read port and output properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // a read of one register number taken at this edge
  sequence s_read(logic [4:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_rsvd;
    reg_rd && (reg_addr == 5'h00 || reg_addr == 5'h0B || reg_addr >= 5'h0F);
  endsequence
  a_read_answers: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered one cycle later");
  a_no_stray_valid: assert property (!reg_rd |=> !reg_rvalid_q)
    else $error("read valid without a read");
  a_reserved_zero: assert property (s_rsvd |=> reg_rdata_q == 16'h0000)
    else $error("reserved register not zero");
  a_word_narrow: assert property (reg_rvalid_q |-> reg_rdata_q[15:7] == 9'h000)
    else $error("read word upper bits set");
  a_out_range: assert property (out_percent_q == 7'h00 ||
    (out_percent_q >= 7'h1E && out_percent_q <= 7'h64))
    else $error("output percent out of range");
  a_out_reported: assert property (s_read(5'h02) |=>
    reg_rdata_q == {9'h000, $past(out_percent_q)})
    else $error("output register differs from output");
  a_kind_board: assert property (s_read(5'h03) ##0 !bus_mode |=>
    reg_rdata_q == {15'h0000, !$past(board_current_sel)})
    else $error("input kind not from board");
  a_dir_bus: assert property (s_read(5'h04) ##0 bus_mode |=>
    reg_rdata_q == {15'h0000, $past(bus_ascending)})
    else $error("direction not from bus");
  a_bypass_read: assert property (s_read(5'h0C) |=>
    reg_rdata_q == {15'h0000, $past(bypass_output_q)})
    else $error("bypass register differs from output");
endmodule : fsmsl_checker

// >>> verif/fsmsl_bus_master.sv
// register read master standing in for the bus side
`timescale 1ns/10ps
module fsmsl_bus_master (
  // clock
  input  wire logic        mclk,
  // read port
  input  wire logic [15:0] reg_rdata_q,
  input  wire logic        reg_rvalid_q,
  output logic             reg_rd,
  output logic [4:0]       reg_addr
);
  initial begin
    reg_rd   = 1'b0;
    reg_addr = 5'h1F;
  end
  // strobe held across one rising edge; the answer is taken one edge on
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    @(negedge mclk);
    reg_rd   = 1'b0;
    reg_addr = ~a;  // scrambled so a stale address cannot pass for a read
    d = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 16'hXXXX;
  endtask : rd
endmodule : fsmsl_bus_master

// >>> verif/fsmsl_top_tb_top.sv
// self-checking bench for the fan speed mode logic
`timescale 1ns/10ps
module fsmsl_top_tb_top;
  localparam int TK = 10;  // shortened millisecond tick keeps runs short
  localparam int KICK = fsmsl_pkg::KICK_MS * TK + 100;
  logic mclk, rst_n, analog_logic_high, remote_switch_input, motor_fault;
  logic board_current_sel, board_ascending, board_kick, board_cut_en;
  logic bus_mode, bus_current_sel, bus_ascending, bus_kick, bus_cut_en;
  logic bus_net_seen, reg_rd, reg_rvalid_q, motor_run_q, bypass_output_q;
  logic green_lamp_q, fault_lamp_q;
  logic [6:0] analog_level, board_ceiling, board_floor, board_cut_value;
  logic [6:0] bus_ceiling, bus_floor, bus_cut_value, out_percent_q;
  logic [1:0] board_rem_mode;
  logic [4:0] reg_addr;
  logic [15:0] reg_rdata_q;
  logic [4:0] rsv [4] = '{5'h00, 5'h0B, 5'h0F, 5'h1F};
  int fail_count = 0;
  int tests_run = 0;
  fsmsl_top #(.TICK_CYCLES(TK)) u_fsmsl_top (.*);
  fsmsl_bus_master u_fsmsl_bus_master (.*);
  // ---------------------------------------------------------------
  // clock, tasks and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic tk(int n);
    repeat (n) @(negedge mclk);
  endtask : tk
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rchk(string nm, logic [4:0] a, logic [15:0] exp);
    logic [15:0] d;
    u_fsmsl_bus_master.rd(a, d);
    chk(nm, d, exp);
  endtask : rchk
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // a hang is cut well after the two kick sequences should end
  initial begin
    repeat (60000) @(posedge mclk);
    fail_count++;
    summarize();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rst_n, analog_logic_high, remote_switch_input, motor_fault} = '0;
    {board_current_sel, board_cut_en, bus_mode, bus_net_seen} = '0;
    {bus_current_sel, bus_ascending, bus_kick, bus_cut_en} = '0;
    {bus_ceiling, bus_floor, bus_cut_value} = '0;
    {board_ascending, board_kick} = 2'h3;
    board_ceiling = 7'h5A;
    board_floor = 7'h28;
    board_cut_value = 7'h3C;
    board_rem_mode = 2'h1;
    analog_level = 7'h64;
    tk(4);
    rst_n = 1'b1;
    foreach (rsv[i]) rchk("reserved", rsv[i], 16'h0000);
    rchk("level", 5'h01, 16'h0064);
    rchk("kind", 5'h03, 16'h0001);
    rchk("dir", 5'h04, 16'h0001);
    rchk("ceiling", 5'h05, 16'h005A);
    rchk("floor", 5'h06, 16'h0028);
    rchk("start", 5'h09, 16'h0001);
    rchk("cut_clamp", 5'h08, 16'h0028);
    // timer press too short, then a long press and release
    remote_switch_input = 1'b1;
    tk(20 * TK);
    remote_switch_input = 1'b0;
    tk(40 * TK);
    rchk("remote_short", 5'h0A, 16'h0000);
    remote_switch_input = 1'b1;
    tk(40 * TK);
    remote_switch_input = 1'b0;
    tk(40 * TK);
    rchk("remote_timer", 5'h0A, 16'h0001);
    rchk("kick_first", 5'h02, 16'h0064);
    tk(KICK);
    rchk("full_asc", 5'h02, 16'h005A);
    rchk("power_on", 5'h0E, 16'h0001);
    chk("green_on", 16'(green_lamp_q), 16'h0001);
    chk("running", 16'(motor_run_q), 16'h0001);
    rchk("bypass_on", 5'h0C, 16'h0001);
    rchk("fault_off", 5'h0D, 16'h0000);
    board_ascending = 1'b0;
    tk(5);
    rchk("full_desc", 5'h02, 16'h0028);
    board_cut_en = 1'b1;
    tk(5);
    rchk("stop_desc", 5'h02, 16'h0000);
    rchk("standby_cut", 5'h0E, 16'h0002);
    analog_level = 7'h3C;
    tk(20);
    rchk("kick_again", 5'h02, 16'h0064);
    tk(KICK);
    rchk("equal_desc", 5'h02, 16'h005A);
    board_ascending = 1'b1;
    analog_level = 7'h00;
    tk(5);
    rchk("stop_asc", 5'h02, 16'h0000);
    chk("stopped", 16'(motor_run_q), 16'h0000);
    // logic mode: a long pulse on the analog pin toggles run off
    board_rem_mode = 2'h2;
    analog_logic_high = 1'b1;
    tk(40 * TK);
    analog_logic_high = 1'b0;
    tk(40 * TK);
    rchk("remote_logic", 5'h0A, 16'h0000);
    // bus settings replace the board ones
    {bus_mode, bus_kick, bus_cut_en, bus_current_sel} = 4'hB;
    bus_ceiling = 7'h50;
    bus_floor = 7'h23;
    bus_cut_value = 7'h46;
    rchk("bus_ceiling", 5'h05, 16'h0050);
    rchk("bus_floor", 5'h06, 16'h0023);
    rchk("bus_start", 5'h09, 16'h0000);
    rchk("bus_cut_en", 5'h07, 16'h0001);
    rchk("bus_cut", 5'h08, 16'h0046);
    rchk("bus_kind", 5'h03, 16'h0000);
    rchk("bus_dir", 5'h04, 16'h0000);
    summarize();
  end
endmodule : fsmsl_top_tb_top
bind fsmsl_top fsmsl_checker u_fsmsl_checker (.*);
